// [rtl/sflm_defs.vh]
// constants of the status, forcing and control-line monitor
`ifndef SFLM_DEFS_VH
`define SFLM_DEFS_VH

// ----------------------------------------------------------------
// register word offsets; the byte address is four times the offset
// ----------------------------------------------------------------
`define SFLM_OFS_SETUP    4'h0
`define SFLM_OFS_STATUS   4'h1
`define SFLM_OFS_ERRWORD  4'h2
`define SFLM_OFS_CTLMAP   4'h3
`define SFLM_OFS_WRCTL    4'h4
`define SFLM_OFS_VECCLR   4'h5
`define SFLM_ADDR_W       6

// ----------------------------------------------------------------
// setup register fields
// ----------------------------------------------------------------
`define SFLM_SET_READY_EN 0
`define SFLM_SET_HOLD_EN  1
`define SFLM_SET_IRQ_TRAP 2
`define SFLM_SET_RUN      3
`define SFLM_SET_W        4
`define SFLM_SETUP_RST    4'h0

// ----------------------------------------------------------------
// status word bits
// ----------------------------------------------------------------
`define SFLM_ST_READY     0
`define SFLM_ST_HOLD      1
`define SFLM_ST_NMI       2
`define SFLM_ST_IRQ       3
`define SFLM_ST_RESET     4
`define SFLM_ST_OPREQ     5
`define SFLM_ST_BUSY      6
`define SFLM_ST_ERROR     7
`define SFLM_ST_CAP       8
`define SFLM_ST_VECT      9
`define SFLM_ST_SUPA      10
`define SFLM_ST_SUPB      11
`define SFLM_ST_GNDA      12
`define SFLM_ST_GNDB      13
`define SFLM_WORD_W       16

// ----------------------------------------------------------------
// control-line map bits and write-control fields
// ----------------------------------------------------------------
`define SFLM_CL_LOCK      0
`define SFLM_CL_GRANT     1
`define SFLM_CL_OPACK     2
`define SFLM_CL_BHE       3
`define SFLM_CL_S1        4
`define SFLM_CL_S0        5
`define SFLM_CL_MIO       6
`define SFLM_CL_COD       7
`define SFLM_CL_N         8
`define SFLM_WR_N         3
`define SFLM_WR_LVL_LSB   8
`define SFLM_CL_RST       8'h00
`define SFLM_CTL_IDLE     8'h05

`endif

// [rtl/sflm_wrctl_pulse.v]
// single-access drive of one writable control line
`timescale 1ns/1ns
module sflm_wrctl_pulse (
  input  wire clk_i,
  input  wire srst_i,
  input  wire req_i,
  input  wire level_i,
  input  wire access_i,
  output wire active_o,
  output wire level_o
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_ARMED = 3'b010;
  localparam [2:0] ST_DRIVE = 3'b100;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg       level_reg;

  // ----------------------------------------------------------------
  // hold level until one target access has ended
  // ----------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (req_i) begin
          state_next = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (access_i) begin
          state_next = ST_DRIVE; // see (RULE14)
        end
      end
      ST_DRIVE: begin
        if (!access_i) begin
          state_next = ST_IDLE; // see (RULE14)
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      state_reg <= ST_IDLE;
      level_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (req_i && state_reg == ST_IDLE) begin
        level_reg <= level_i;
      end
    end
  end

  assign active_o = (state_reg != ST_IDLE);
  assign level_o  = level_reg;

endmodule

// [rtl/sflm_monitor.v]
// status, forcing and control-line monitor of the emulator pod
//
// How it works
// (RULE1) high ready (not ready) or high hold request is the forcing condition
// (RULE2) a setup-disabled ready or hold line reaches the internal processor only in run mode
// (RULE3) an enabled user-enableable line is never reported as forcing error
// (RULE4) error, busy, operand request, reset blocked outside run mode; reported if active
// (RULE5) nmi blocked outside run mode, still reported, shown in status bit 2
// (RULE6) interrupt reporting off after reset, on only when the trap is selected
// (RULE7) pseudo-status bits are generated inside and read with the real lines
// (RULE8) each supply out of 4.5 to 5.5 volts sets its own fault bit
// (RULE9) each ground pin is latched; a high level flags that ground open
// (RULE10) vector capture bit set after acknowledge, cleared only by its clear address
// (RULE11) failed bias capacitor check sets the capacitor fault bit
// (RULE12) 8-bit control map, bits 0 to 7 lines, set bit marks faulty line
// (RULE13) only bus lock, hold grant and operand acknowledge are writable
// (RULE14) a write-control level lasts one target access, then goes inactive
// (RULE15) a high hold request floats address, data and bus control outputs
// (RULE16) a supply below 3.5 volts floats those lines and hold grant too
// (RULE17) the mainframe keeps resetting the device until the supply recovers
// (RULE18) error word shows active lines as ones; status shows true levels
// (RULE19) disabled user-enableable lines stay monitored and reported when asserted
// (RULE20) hold grant driven by write control does not float the bus
// (RULE21) all indications gathered into one 16-bit word per status read
//
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "sflm_defs.vh"
module sflm_monitor (
  input  wire        clk_i,
  input  wire        srst_i,
  input  wire [5:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  output wire [31:0] avs_readdata_o,
  output wire        avs_waitrequest_o,
  input  wire        ready_n_i,
  input  wire        hold_i,
  input  wire        nmi_i,
  input  wire        maskable_irq_i,
  input  wire        reset_i,
  input  wire        coprocessor_operand_request_i,
  input  wire        busy_n_i,
  input  wire        error_n_i,
  input  wire        supply_a_low_i,
  input  wire        supply_a_high_i,
  input  wire        supply_a_uv_i,
  input  wire        supply_b_low_i,
  input  wire        supply_b_high_i,
  input  wire        supply_b_uv_i,
  input  wire        ground_a_i,
  input  wire        ground_b_i,
  input  wire        ground_sample_i,
  input  wire        cap_check_done_i,
  input  wire        cap_in_tol_i,
  input  wire        inta_done_i,
  input  wire        access_i,
  input  wire        cpu_hold_grant_i,
  input  wire [4:0]  cpu_ctl_i,
  input  wire [7:0]  ctl_sense_i,
  output wire        cpu_ready_n_o,
  output wire        cpu_hold_o,
  output wire        cpu_nmi_o,
  output wire        cpu_reset_o,
  output wire        cpu_operand_request_o,
  output wire        cpu_busy_n_o,
  output wire        cpu_error_n_o,
  output wire [7:0]  ctl_o,
  output wire        bus_oe_n_o,
  output wire        hold_grant_oe_n_o
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  reg [`SFLM_SET_W-1:0]    setup_reg;
  reg [`SFLM_CL_N-1:0]     ctlmap_reg;
  reg                      vect_reg;
  reg                      cap_fault_reg;
  reg                      gnd_a_reg;
  reg                      gnd_b_reg;
  reg                      wait_reg;
  reg [31:0]               rdata_reg;
  reg                      cpu_ready_n_reg;
  reg                      cpu_hold_reg;
  reg                      cpu_nmi_reg;
  reg                      cpu_reset_reg;
  reg                      cpu_opreq_reg;
  reg                      cpu_busy_n_reg;
  reg                      cpu_error_n_reg;
  reg [`SFLM_CL_N-1:0]     ctl_reg;
  reg                      bus_oe_n_reg;
  reg                      grant_oe_n_reg;
  reg [`SFLM_WORD_W-1:0]   status_word;
  reg [`SFLM_WORD_W-1:0]   err_word;
  reg [`SFLM_CL_N-1:0]     ctl_next;
  reg [31:0]               rdata_next;

  wire                     ready_en;
  wire                     hold_en;
  wire                     irq_trap;
  wire                     run_mode;
  wire                     req;
  wire                     wr_take;
  wire                     wr_pulse;
  wire [`SFLM_WR_N-1:0]    wr_active;
  wire [`SFLM_WR_N-1:0]    wr_level;
  wire                     undervolt;
  wire                     hold_float;
  wire [`SFLM_CL_N-1:0]    ctl_fault;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function is_reg;
    input [`SFLM_ADDR_W-1:0] addr;
    input [3:0]              index;
    begin
      is_reg = (addr == {index, 2'b00});
    end
  endfunction

  assign ready_en  = setup_reg[`SFLM_SET_READY_EN];
  assign hold_en   = setup_reg[`SFLM_SET_HOLD_EN];
  assign irq_trap  = setup_reg[`SFLM_SET_IRQ_TRAP];
  assign run_mode  = setup_reg[`SFLM_SET_RUN];
  assign req       = avs_read_i || avs_write_i;
  assign wr_take   = avs_write_i && !wait_reg;
  assign wr_pulse  = wr_take && is_reg(avs_address_i, `SFLM_OFS_WRCTL);
  assign undervolt = supply_a_uv_i || supply_b_uv_i;
  // a hold grant forced by write control leaves the bus driven
  assign hold_float = hold_i && !wr_active[`SFLM_CL_GRANT]; // see (RULE15) see (RULE20)

  // ----------------------------------------------------------------
  // single-access write-control units, one per writable line
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `SFLM_WR_N; gi = gi + 1) begin : g_wr
      sflm_wrctl_pulse u_pulse (
        .clk_i    (clk_i),
        .srst_i   (srst_i),
        .req_i    (wr_pulse && avs_writedata_i[gi]), // see (RULE13)
        .level_i  (avs_writedata_i[`SFLM_WR_LVL_LSB + gi]),
        .access_i (access_i),
        .active_o (wr_active[gi]),
        .level_o  (wr_level[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // status and error words
  // ----------------------------------------------------------------
  always @* begin
    status_word                  = {`SFLM_WORD_W{1'b0}};
    status_word[`SFLM_ST_READY]  = ready_n_i;
    status_word[`SFLM_ST_HOLD]   = hold_i;
    status_word[`SFLM_ST_NMI]    = nmi_i; // see (RULE5)
    status_word[`SFLM_ST_IRQ]    = maskable_irq_i;
    status_word[`SFLM_ST_RESET]  = reset_i;
    status_word[`SFLM_ST_OPREQ]  = coprocessor_operand_request_i;
    status_word[`SFLM_ST_BUSY]   = busy_n_i;
    status_word[`SFLM_ST_ERROR]  = error_n_i; // see (RULE18)
    // pseudo-status bits beside the real lines
    status_word[`SFLM_ST_CAP]    = cap_fault_reg; // see (RULE7) see (RULE21)
    status_word[`SFLM_ST_VECT]   = vect_reg;
    status_word[`SFLM_ST_SUPA]   = supply_a_low_i || supply_a_high_i; // see (RULE8)
    status_word[`SFLM_ST_SUPB]   = supply_b_low_i || supply_b_high_i; // see (RULE8)
    status_word[`SFLM_ST_GNDA]   = gnd_a_reg; // see (RULE9)
    status_word[`SFLM_ST_GNDB]   = gnd_b_reg; // see (RULE9)
  end

  always @* begin
    err_word = {`SFLM_WORD_W{1'b0}};
    // enabled lines never flagged, disabled ones always watched
    err_word[`SFLM_ST_READY] = ready_n_i && !ready_en; // see (RULE1) see (RULE3) see (RULE19)
    err_word[`SFLM_ST_HOLD]  = hold_i && !hold_en; // see (RULE1) see (RULE3) see (RULE19)
    err_word[`SFLM_ST_NMI]   = nmi_i && irq_trap; // see (RULE5) see (RULE6)
    err_word[`SFLM_ST_IRQ]   = maskable_irq_i && irq_trap; // see (RULE6)
    // active level shown as one whatever the pin polarity
    err_word[`SFLM_ST_RESET] = reset_i && !run_mode; // see (RULE4) see (RULE18)
    err_word[`SFLM_ST_OPREQ] = coprocessor_operand_request_i && !run_mode; // see (RULE4)
    err_word[`SFLM_ST_BUSY]  = !busy_n_i && !run_mode; // see (RULE4) see (RULE18)
    err_word[`SFLM_ST_ERROR] = !error_n_i && !run_mode; // see (RULE4) see (RULE18)
    err_word[`SFLM_ST_CAP]   = cap_fault_reg; // see (RULE11)
  end

  // ----------------------------------------------------------------
  // control lines toward the target
  // ----------------------------------------------------------------
  always @* begin
    ctl_next                 = {`SFLM_CL_N{1'b0}};
    ctl_next[`SFLM_CL_LOCK]  = wr_active[`SFLM_CL_LOCK] ? wr_level[`SFLM_CL_LOCK] : 1'b1;
    ctl_next[`SFLM_CL_GRANT] = wr_active[`SFLM_CL_GRANT] ? wr_level[`SFLM_CL_GRANT] :
                               cpu_hold_grant_i; // see (RULE14)
    ctl_next[`SFLM_CL_OPACK] = wr_active[`SFLM_CL_OPACK] ? wr_level[`SFLM_CL_OPACK] : 1'b1;
    ctl_next[`SFLM_CL_COD:`SFLM_CL_BHE] = cpu_ctl_i;
  end

  // lines compared against their sensed level while driven in an access
  assign ctl_fault = (ctl_sense_i ^ ctl_reg) &
                     {{`SFLM_CL_N-2{!bus_oe_n_reg}}, !grant_oe_n_reg, !bus_oe_n_reg} &
                     {`SFLM_CL_N{access_i}};

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always @* begin
    rdata_next = 32'h0000_0000;
    if (is_reg(avs_address_i, `SFLM_OFS_SETUP)) begin
      rdata_next[`SFLM_SET_W-1:0] = setup_reg;
    end else if (is_reg(avs_address_i, `SFLM_OFS_STATUS)) begin
      rdata_next[`SFLM_WORD_W-1:0] = status_word; // see (RULE21)
    end else if (is_reg(avs_address_i, `SFLM_OFS_ERRWORD)) begin
      rdata_next[`SFLM_WORD_W-1:0] = err_word;
    end else if (is_reg(avs_address_i, `SFLM_OFS_CTLMAP)) begin
      rdata_next[`SFLM_CL_N-1:0] = ctlmap_reg; // see (RULE12)
    end else if (is_reg(avs_address_i, `SFLM_OFS_WRCTL)) begin
      rdata_next[`SFLM_WR_N-1:0] = wr_active;
      rdata_next[`SFLM_WR_LVL_LSB+`SFLM_WR_N-1:`SFLM_WR_LVL_LSB] = wr_level;
    end
  end

  // ----------------------------------------------------------------
  // bus slave and sticky bits
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (srst_i) begin
      wait_reg      <= 1'b1;
      rdata_reg     <= 32'h0000_0000;
      setup_reg     <= `SFLM_SETUP_RST; // see (RULE6)
      ctlmap_reg    <= `SFLM_CL_RST;
      vect_reg      <= 1'b0;
      cap_fault_reg <= 1'b0;
      gnd_a_reg     <= 1'b0;
      gnd_b_reg     <= 1'b0;
    end else begin
      if (req && wait_reg) begin
        wait_reg  <= 1'b0;
        rdata_reg <= rdata_next;
      end else begin
        wait_reg  <= 1'b1;
      end
      if (wr_take && is_reg(avs_address_i, `SFLM_OFS_SETUP)) begin
        setup_reg <= avs_writedata_i[`SFLM_SET_W-1:0];
      end
      // fresh faults win over a write-one clear
      if (wr_take && is_reg(avs_address_i, `SFLM_OFS_CTLMAP)) begin
        ctlmap_reg <= (ctlmap_reg & ~avs_writedata_i[`SFLM_CL_N-1:0]) | ctl_fault;
      end else begin
        ctlmap_reg <= ctlmap_reg | ctl_fault; // see (RULE12)
      end
      if (inta_done_i) begin
        vect_reg <= 1'b1; // see (RULE10)
      end else if (wr_take && is_reg(avs_address_i, `SFLM_OFS_VECCLR)) begin
        vect_reg <= 1'b0; // see (RULE10)
      end
      if (cap_check_done_i) begin
        cap_fault_reg <= !cap_in_tol_i; // see (RULE11)
      end
      if (ground_sample_i) begin
        gnd_a_reg <= ground_a_i; // see (RULE9)
        gnd_b_reg <= ground_b_i; // see (RULE9)
      end
    end
  end

  // ----------------------------------------------------------------
  // gated inputs to the internal processor and output drive
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (srst_i) begin
      cpu_ready_n_reg <= 1'b0;
      cpu_hold_reg    <= 1'b0;
      cpu_nmi_reg     <= 1'b0;
      cpu_reset_reg   <= 1'b0;
      cpu_opreq_reg   <= 1'b0;
      cpu_busy_n_reg  <= 1'b1;
      cpu_error_n_reg <= 1'b1;
      ctl_reg         <= `SFLM_CTL_IDLE;
      bus_oe_n_reg    <= 1'b1;
      grant_oe_n_reg  <= 1'b1;
    end else begin
      cpu_ready_n_reg <= ready_n_i && (ready_en || run_mode); // see (RULE2)
      cpu_hold_reg    <= hold_i && (hold_en || run_mode); // see (RULE2)
      cpu_nmi_reg     <= nmi_i && run_mode; // see (RULE5)
      cpu_reset_reg   <= reset_i && run_mode; // see (RULE4)
      cpu_opreq_reg   <= coprocessor_operand_request_i && run_mode; // see (RULE4)
      cpu_busy_n_reg  <= busy_n_i || !run_mode; // see (RULE4)
      cpu_error_n_reg <= error_n_i || !run_mode; // see (RULE4)
      ctl_reg         <= ctl_next;
      // undervoltage floats everything until the supply is back
      bus_oe_n_reg    <= hold_float || undervolt; // see (RULE15) see (RULE16)
      grant_oe_n_reg  <= undervolt; // see (RULE16)
    end
  end

  assign avs_readdata_o        = rdata_reg;
  assign avs_waitrequest_o     = wait_reg;
  assign cpu_ready_n_o         = cpu_ready_n_reg;
  assign cpu_hold_o            = cpu_hold_reg;
  assign cpu_nmi_o             = cpu_nmi_reg;
  assign cpu_reset_o           = cpu_reset_reg;
  assign cpu_operand_request_o = cpu_opreq_reg;
  assign cpu_busy_n_o          = cpu_busy_n_reg;
  assign cpu_error_n_o         = cpu_error_n_reg;
  assign ctl_o                 = ctl_reg;
  assign bus_oe_n_o            = bus_oe_n_reg;
  assign hold_grant_oe_n_o     = grant_oe_n_reg;

endmodule

// [tb/sflm_monitor_assertions.sv]
// port checker of the status and control-line monitor
`timescale 1ns/1ns
module sflm_monitor_assertions (
  input wire        clk_i,
  input wire        srst_i,
  input wire [5:0]  avs_address_i,
  input wire        avs_read_i,
  input wire        avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire        avs_waitrequest_o,
  input wire        hold_i,
  input wire        supply_a_uv_i,
  input wire        supply_b_uv_i,
  input wire        access_i,
  input wire        cpu_ready_n_o,
  input wire        cpu_hold_o,
  input wire        cpu_nmi_o,
  input wire        cpu_reset_o,
  input wire        cpu_operand_request_o,
  input wire        cpu_busy_n_o,
  input wire        cpu_error_n_o,
  input wire [7:0]  ctl_o,
  input wire        bus_oe_n_o,
  input wire        hold_grant_oe_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  reg  [3:0] setup_reg;
  reg        wrd_reg;
  wire       acc_w = avs_write_i && !avs_waitrequest_o;
  // shadow of the setup register, flag of a pending hold grant pulse
  always @(posedge clk_i) begin
    if (srst_i) begin
      setup_reg <= 4'h0;
      wrd_reg   <= 1'b0;
    end else begin
      if (acc_w && avs_address_i == 6'h00) begin
        setup_reg <= avs_writedata_i[3:0];
      end
      if (acc_w && avs_address_i == 6'h10 && avs_writedata_i[1]) begin
        wrd_reg <= 1'b1;
      end else if ($fell(access_i)) begin
        wrd_reg <= 1'b0;
      end
    end
  end
  property p_ready_block;
    !setup_reg[0] && !setup_reg[3] && $stable(setup_reg) |=> !cpu_ready_n_o;
  endproperty
  a_ready_block: assert property (p_ready_block) else $error("ready passed");
  property p_hold_block;
    !setup_reg[1] && !setup_reg[3] && $stable(setup_reg) |=> !cpu_hold_o;
  endproperty
  a_hold_block: assert property (p_hold_block) else $error("hold passed");
  property p_run_block;
    !setup_reg[3] && $stable(setup_reg) |=> ##[0:1] (cpu_busy_n_o && cpu_error_n_o
      && !cpu_reset_o && !cpu_operand_request_o) [*2];
  endproperty
  a_run_block: assert property (p_run_block) else $error("forcing input passed");
  property p_nmi_block;
    !setup_reg[3] && $stable(setup_reg) |=> !cpu_nmi_o;
  endproperty
  a_nmi_block: assert property (p_nmi_block) else $error("nmi passed");
  property p_wait_low;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_wait_low: assert property (p_wait_low) else $error("no answer");
  property p_wait_high;
    !avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_wait_high: assert property (p_wait_high) else $error("wait low too long");
  property p_uv_float;
    supply_a_uv_i || supply_b_uv_i |=> bus_oe_n_o && hold_grant_oe_n_o;
  endproperty
  a_uv_float: assert property (p_uv_float) else $error("driven in undervolt");
  property p_hold_float;
    hold_i && !wrd_reg |=> bus_oe_n_o;
  endproperty
  a_hold_float: assert property (p_hold_float) else $error("driven in hold");
  property p_pulse_end;
    $fell(access_i) |-> ##2 (ctl_o[0] && ctl_o[2]);
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("line not idle");
  c_wrctl: cover property (acc_w && avs_address_i == 6'h10);
  c_uv: cover property (supply_a_uv_i && !srst_i);
  c_access: cover property ($fell(access_i));
endmodule

// [tb/sflm_target_model.sv]
// target-board model: access cycles and sensed control-line levels
`timescale 1ns/1ns
module sflm_target_model (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [7:0] stuck_i,
  input  wire logic [7:0] ctl_i,
  input  wire logic       bus_oe_n_i,
  input  wire logic       grant_oe_n_i,
  output logic            access_o,
  output logic [7:0]      sense_o
);
  logic [2:0] left_reg = 3'h0;
  logic [7:0] last_reg = 8'h00;
  logic [7:0] drv_w;
  assign drv_w = {{6{~bus_oe_n_i}}, ~grant_oe_n_i, ~bus_oe_n_i};
  // driven pins read back, stuck ones inverted; released pins drift
  assign sense_o = (drv_w & (ctl_i ^ stuck_i)) | (~drv_w & ~last_reg);
  assign access_o = (left_reg != 3'h0);
  always @(posedge clk_i) begin
    last_reg <= sense_o;
    if (go_i) begin
      left_reg <= 3'h4;
    end else if (left_reg != 3'h0) begin
      left_reg <= left_reg - 3'h1;
    end
  end
endmodule

// [tb/tb.sv]
// self-checking bench of the status and control-line monitor
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic [5:0]  avs_address_i = 6'h00;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  wire  [31:0] avs_readdata_o;
  wire         avs_waitrequest_o;
  logic [7:0]  pv = 8'h0c;
  logic [5:0]  sup = 6'h00;
  logic [1:0]  gnd = 2'h0;
  logic [3:0]  ev = 4'h4;
  logic [4:0]  cctl = 5'h00;
  logic        go = 1'b0;
  logic        hg = 1'b0;
  logic [7:0]  stuck = 8'h00;
  wire         access_w;
  wire  [7:0]  sense_w;
  wire  [7:0]  ctl_o;
  wire  [6:0]  cpu_w;
  wire         bus_oe_n_o;
  wire         hold_grant_oe_n_o;
  integer      seed = 32'hb5ee;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          cyc = 0;
  logic [31:0] q;
  logic [3:0]  st = 4'h0;
  logic        lv;
  sflm_monitor dut (.clk_i(clk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .ready_n_i(pv[0]), .hold_i(pv[1]), .nmi_i(pv[2]), .maskable_irq_i(pv[3]),
    .reset_i(pv[4]), .coprocessor_operand_request_i(pv[5]), .busy_n_i(pv[6]),
    .error_n_i(pv[7]), .supply_a_low_i(sup[0]), .supply_a_high_i(sup[1]),
    .supply_a_uv_i(sup[2]), .supply_b_low_i(sup[3]), .supply_b_high_i(sup[4]),
    .supply_b_uv_i(sup[5]), .ground_a_i(gnd[0]), .ground_b_i(gnd[1]),
    .ground_sample_i(ev[0]), .cap_check_done_i(ev[1]), .cap_in_tol_i(ev[2]),
    .inta_done_i(ev[3]), .access_i(access_w), .cpu_hold_grant_i(hg), .cpu_ctl_i(cctl),
    .ctl_sense_i(sense_w), .cpu_ready_n_o(cpu_w[0]), .cpu_hold_o(cpu_w[1]),
    .cpu_nmi_o(cpu_w[2]), .cpu_reset_o(cpu_w[3]), .cpu_operand_request_o(cpu_w[4]),
    .cpu_busy_n_o(cpu_w[5]), .cpu_error_n_o(cpu_w[6]), .ctl_o(ctl_o),
    .bus_oe_n_o(bus_oe_n_o), .hold_grant_oe_n_o(hold_grant_oe_n_o));
  sflm_target_model u_tgt (.clk_i(clk_i), .go_i(go), .stuck_i(stuck), .ctl_i(ctl_o),
    .bus_oe_n_i(bus_oe_n_o), .grant_oe_n_i(hold_grant_oe_n_o), .access_o(access_w),
    .sense_o(sense_w));
  function automatic [31:0] f_stat(input [7:0] p, input [5:0] s, input [1:0] g,
                                   input c, input v);
    f_stat = {18'h0, g, s[4] | s[3], s[1] | s[0], v, c, p};
  endfunction
  function automatic [31:0] f_err(input [7:0] p, input [3:0] u, input c);
    logic r;
    r = !u[3];
    f_err = {23'h0, c, ~p[7] & r, ~p[6] & r, p[5] & r, p[4] & r, p[3] & u[2],
             p[2] & u[2], p[1] & !u[1], p[0] & !u[0]};
  endfunction
  function automatic [4:0] f_cpu(input [7:0] p, input [3:0] u);
    f_cpu = u[3] ? {p[7:4], p[2]} : 5'b11000;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge clk_i);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic rchk(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      end_of_test;
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    tick(12);
    `CHK(ctl_o[2:0], 3'b101)
    srst_i <= 1'b0;
    rchk(6'h00, 32'h0);
    rchk(6'h08, f_err(pv, 4'h0, 1'b0));
    rchk(6'h0c, 32'h0);
    rchk(6'h18, 32'h0);
    rchk(6'h01, 32'h0);
    bus(1'b1, 6'h04, 32'hffff);
    rchk(6'h04, f_stat(pv, sup, 2'h0, 1'b0, 1'b0));
    sup <= 6'h04;
    repeat (3) begin
      srst_i <= 1'b1;
      tick(1);
      srst_i <= 1'b0;
      tick(2);
      `CHK({bus_oe_n_o, hold_grant_oe_n_o}, 2'b11)
    end
    sup <= 6'h00;
    tick(3);
    `CHK({bus_oe_n_o, hold_grant_oe_n_o}, 2'b00)
    for (int i = 0; i < 40; i++) begin
      st = 4'($random(seed));
      pv <= 8'($random(seed));
      sup <= 6'($random(seed)) & 6'h1b;
      cctl <= 5'($random(seed));
      hg <= 1'($random(seed));
      bus(1'b1, 6'h00, {28'h0, st});
      tick(2);
      rchk(6'h00, {28'h0, st});
      rchk(6'h04, f_stat(pv, sup, 2'h0, 1'b0, 1'b0));
      rchk(6'h08, f_err(pv, st, 1'b0));
      `CHK(cpu_w[6:2], f_cpu(pv, st))
      `CHK(cpu_w[1:0], pv[1:0] & (st[1:0] | {2{st[3]}}))
      `CHK({ctl_o[7:3], ctl_o[1]}, {cctl, hg})
      `CHK(bus_oe_n_o, pv[1])
    end
    gnd <= 2'b10;
    @(posedge clk_i);
    ev <= 4'hb;
    @(posedge clk_i);
    ev <= 4'h4;
    gnd <= 2'b00;
    rchk(6'h04, f_stat(pv, sup, 2'b10, 1'b1, 1'b1));
    rchk(6'h08, f_err(pv, st, 1'b1));
    bus(1'b1, 6'h14, 32'h1);
    rchk(6'h04, f_stat(pv, sup, 2'b10, 1'b1, 1'b0));
    pv <= 8'hc0;
    hg <= 1'b0;
    stuck <= 8'h01;
    for (int j = 0; j < 3; j++) begin
      lv = (j == 1);
      pv[1] <= lv;
      bus(1'b1, 6'h10, (32'h1 << j) | (lv ? 32'h200 : 32'h0));
      tick(2);
      `CHK(ctl_o[j], lv)
      `CHK(bus_oe_n_o, 1'b0)
      go <= 1'b1;
      tick(1);
      go <= 1'b0;
      tick(2);
      `CHK(ctl_o[j], lv)
      tick(6);
      `CHK(ctl_o[j], !lv)
    end
    rchk(6'h0c, 32'h1);
    bus(1'b1, 6'h0c, 32'h1);
    rchk(6'h0c, 32'h0);
    end_of_test;
  end
endmodule
bind sflm_monitor sflm_monitor_assertions u_chk (.clk_i(clk_i), .srst_i(srst_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_waitrequest_o(avs_waitrequest_o),
  .hold_i(hold_i), .supply_a_uv_i(supply_a_uv_i), .supply_b_uv_i(supply_b_uv_i),
  .access_i(access_i), .cpu_ready_n_o(cpu_ready_n_o), .cpu_hold_o(cpu_hold_o),
  .cpu_nmi_o(cpu_nmi_o), .cpu_reset_o(cpu_reset_o),
  .cpu_operand_request_o(cpu_operand_request_o), .cpu_busy_n_o(cpu_busy_n_o),
  .cpu_error_n_o(cpu_error_n_o), .ctl_o(ctl_o), .bus_oe_n_o(bus_oe_n_o),
  .hold_grant_oe_n_o(hold_grant_oe_n_o));
